// ### rtl/kip_pkg.sv
package kip_pkg;
   // register word indices; the byte address on the bus is index * 4
   localparam logic [7:0] KIP_IDX_MODE   = 8'h10;
   localparam logic [7:0] KIP_IDX_CTRL   = 8'h11;
   localparam logic [7:0] KIP_IDX_IE     = 8'h12;
   localparam logic [7:0] KIP_IDX_LEVEL  = 8'h13;
   localparam logic [7:0] KIP_IDX_STAT   = 8'h14;
   localparam logic [7:0] KIP_IDX_MASK   = 8'h15;
   localparam logic [9:0] KIP_ADDR_MODE  = {KIP_IDX_MODE, 2'b00};
   localparam logic [9:0] KIP_ADDR_CTRL  = {KIP_IDX_CTRL, 2'b00};
   localparam logic [9:0] KIP_ADDR_IE    = {KIP_IDX_IE, 2'b00};
   localparam logic [9:0] KIP_ADDR_LEVEL = {KIP_IDX_LEVEL, 2'b00};
   localparam logic [9:0] KIP_ADDR_STAT  = {KIP_IDX_STAT, 2'b00};
   localparam logic [9:0] KIP_ADDR_MASK  = {KIP_IDX_MASK, 2'b00};
   // control register field positions
   localparam int KIP_CTRL_RATE_BIT = 0;
   localparam int KIP_CTRL_PULL_BIT = 1;
   // status bit positions
   localparam int KIP_ST_KEY_BIT  = 0;
   localparam int KIP_ST_HOLD_BIT = 1;
   // reset values
   localparam logic [3:0] KIP_IE_RST   = 4'h0;
   localparam logic       KIP_RATE_RST = 1'b0;
   localparam logic [1:0] KIP_STAT_RST = 2'h0;
   localparam logic [1:0] KIP_MASK_RST = 2'h0;
   // timing: clock and sampling rates
   localparam longint KIP_CLK_HZ    = 200000000;
   localparam longint KIP_SLOW_HZ   = 128;
   localparam longint KIP_FAST_HZ   = 4000;
   localparam longint KIP_SLOW_DIV  = KIP_CLK_HZ / KIP_SLOW_HZ;
   localparam longint KIP_FAST_DIV  = KIP_CLK_HZ / KIP_FAST_HZ;
   // hold time for multi-key reset, in ms (between 2 and 3 s)
   localparam longint KIP_HOLD_MS   = 2500;
   localparam longint KIP_HOLD_TICKS = KIP_HOLD_MS * KIP_SLOW_HZ / 1000;
endpackage

// ### rtl/kip_port.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
// How it works
// - pin level register reads synchronised pin levels; writes are ignored
// - per-pin mode bit: 0 pull resistor attached, 1 high impedance
// - control bit 1 sets shared pull polarity: 0 down, 1 up
// - control bit 0 picks sampling clock: 0 is 128 Hz, 1 is 4 kHz
// - reset clears all interrupt enables and selects 128 Hz sampling
// - mode bits reset to a fixed configuration parameter value
// - pull polarity resets to a fixed configuration parameter value
// - each enable bit lets its pin join the port interrupt
// - enabled pins are ORed into a single port interrupt source
// - detection is evaluated once per tick of the chosen sampling rate
// - request pulse and flag follow a change within one sample period
// - pull-down: any pin rising from all-low, or all returning low, triggers
// - pull-up: any pin falling from all-high, or all returning high, triggers
// - port interrupt is serviced at vector address 001EH
// - configured number of pins held two to three seconds requests reset
module kip_port
   import kip_pkg::*;
#(
   parameter logic [3:0]  MODE_RST     = 4'h0,
   parameter logic        PULL_RST     = 1'b0,
   parameter logic [2:0]  HOLD_KEYS    = 3'd2,
   parameter logic [11:0] VECTOR_ADDR  = 12'h01e,
   parameter int          SLOW_DIV     = int'(KIP_SLOW_DIV),
   parameter int          FAST_DIV     = int'(KIP_FAST_DIV),
   parameter int          HOLD_TICKS   = int'(KIP_HOLD_TICKS)
)(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // key pins and pad controls
   input  wire logic [3:0]  key_pin,
   output logic [3:0]       pull_enable,
   output logic             pull_up,
   // interrupt controller side
   input  wire logic        key_port_irq_ack,
   output logic             key_port_irq_request,
   output logic             key_port_irq_flag,
   output logic [11:0]      irq_vector,
   // reset-mode request and summary interrupt
   output logic             reset_mode_request,
   output logic             irq
);

   // all state of the port in one record, registered by a single process
   typedef struct packed {
      // two-stage synchroniser for the asynchronous key pins
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      // software-visible control and status
      logic [3:0]  mode;
      logic        pull;
      logic        rate;
      logic [3:0]  ie;
      logic [1:0]  stat;
      logic [1:0]  mask;
      // sampling divider and change detector
      logic [31:0] div;
      logic        last_or;
      logic        req;
      logic        flag;
      // multi-key hold timer, paced by its own slow divider
      logic [31:0] slow_div;
      logic [15:0] hold;
      logic        rst_req;
      // bus answer and registered outputs
      logic        ready;
      logic [31:0] rdata;
      logic        err;
      logic        irq;
      logic [11:0] vec;
   } kip_state_t;

   kip_state_t st_reg;
   kip_state_t st_next;

   // count of ones in a nibble
   function automatic logic [2:0] kip_ones(input logic [3:0] v);
      kip_ones = 3'({2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]});
   endfunction

   // polarity-adjusted levels: under pull-up an idle pin reads as zero
   function automatic logic [3:0] kip_polar(input logic [3:0] v, input logic up);
      kip_polar = up ? ~v : v;
   endfunction

   // divider end point; a compare with >= keeps a rate switch from
   // stranding a count that already ran past the new, shorter end point
   function automatic logic kip_wrap(input logic [31:0] cnt, input logic [31:0] top);
      kip_wrap = (cnt >= top);
   endfunction

   // register selected by the word address of an access
   typedef enum {
      SEL_MODE,
      SEL_CTRL,
      SEL_IE,
      SEL_LEVEL,
      SEL_STAT,
      SEL_MASK,
      SEL_NONE
   } kip_sel_t;

   // one decoder shared by writes and reads, so the two maps cannot drift
   function automatic kip_sel_t kip_decode(input logic [11:0] a);
      kip_sel_t s;
      s = SEL_NONE;
      case (a[11:2])
         {2'b00, KIP_IDX_MODE}:
         begin
            s = SEL_MODE;
         end
         {2'b00, KIP_IDX_CTRL}:
         begin
            s = SEL_CTRL;
         end
         {2'b00, KIP_IDX_IE}:
         begin
            s = SEL_IE;
         end
         {2'b00, KIP_IDX_LEVEL}:
         begin
            s = SEL_LEVEL;
         end
         {2'b00, KIP_IDX_STAT}:
         begin
            s = SEL_STAT;
         end
         {2'b00, KIP_IDX_MASK}:
         begin
            s = SEL_MASK;
         end
         default:
         begin
            s = SEL_NONE;
         end
      endcase
      kip_decode = s;
   endfunction

   logic        tick;
   logic        slow_tick;
   logic        acc;
   logic        wr;
   logic        cur_or;
   logic [3:0]  pressed;
   logic [3:0]  active;
   logic [31:0] div_top;
   kip_sel_t    sel;

   // sampling divider end point, hold-timer pacing, apb access phase and decode
   always_comb
   begin
      div_top   = st_reg.rate ? 32'(FAST_DIV - 1) : 32'(SLOW_DIV - 1);
      tick      = kip_wrap(st_reg.div, div_top);
      slow_tick = kip_wrap(st_reg.slow_div, 32'(SLOW_DIV - 1));
      acc       = psel && penable && !st_reg.ready;
      wr        = acc && pwrite;
      sel       = kip_decode(paddr);
      // invert under pull-up so idle reads as zero, then mask and merge
      pressed   = kip_polar(st_reg.sync2, st_reg.pull);
      active    = pressed & st_reg.ie;
      cur_or    = |active;
   end

   // next-state logic
   always_comb
   begin
      st_next       = st_reg;
      st_next.sync1 = key_pin;
      st_next.sync2 = st_reg.sync1;
      st_next.ready = acc;
      st_next.err   = 1'b0;
      st_next.rdata = 32'h0;
      st_next.req   = 1'b0;
      st_next.div   = tick ? 32'h0 : st_reg.div + 32'h1;
      st_next.slow_div = slow_tick ? 32'h0 : st_reg.slow_div + 32'h1;
      // the vector is held in a flip-flop like every other output
      st_next.vec   = VECTOR_ADDR;

      // edge of the OR result between samples; the flag covers both
      // directions, which gives the any-pin / all-pins behaviour
      if (tick)
      begin
         st_next.last_or = cur_or;
         if (cur_or != st_reg.last_or)
         begin
            st_next.req = 1'b1;
         end
      end

      // flag: set wins over acknowledge
      if (key_port_irq_ack)
      begin
         st_next.flag = 1'b0;
      end
      if (st_next.req)
      begin
         st_next.flag = 1'b1;
      end

      // multi-key hold timer runs on slow ticks regardless of selected rate
      // so the hold time does not depend on the interrupt sampling choice;
      // every pin counts here, enabled for the interrupt or not
      if (kip_ones(pressed) >= HOLD_KEYS)
      begin
         if (slow_tick && st_reg.hold != 16'(HOLD_TICKS))
         begin
            st_next.hold = st_reg.hold + 16'h1;
         end
         if (st_reg.hold == 16'(HOLD_TICKS))
         begin
            st_next.rst_req = 1'b1;
         end
      end
      else
      begin
         st_next.hold    = 16'h0;
         st_next.rst_req = 1'b0;
      end

      // register writes
      if (wr)
      begin
         case (sel)
            SEL_MODE:
            begin
               st_next.mode = pwdata[3:0];
            end
            SEL_CTRL:
            begin
               st_next.pull = pwdata[KIP_CTRL_PULL_BIT];
               st_next.rate = pwdata[KIP_CTRL_RATE_BIT];
            end
            SEL_IE:
            begin
               st_next.ie = pwdata[3:0];
            end
            SEL_STAT:
            begin
               // write one to clear; a set in this cycle is applied below and wins
               st_next.stat = st_reg.stat & ~pwdata[1:0];
            end
            SEL_MASK:
            begin
               st_next.mask = pwdata[1:0];
            end
            SEL_LEVEL:
            begin
               // the level register has no storage, so a write is dropped quietly
               st_next.err = 1'b0;
            end
            default:
            begin
               st_next.err = 1'b1;
            end
         endcase
      end
      else if (acc)
      begin
         case (sel)
            SEL_MODE:
            begin
               st_next.rdata = {28'h0, st_reg.mode};
            end
            SEL_CTRL:
            begin
               st_next.rdata = {30'h0, st_reg.pull, st_reg.rate};
            end
            SEL_IE:
            begin
               st_next.rdata = {28'h0, st_reg.ie};
            end
            SEL_LEVEL:
            begin
               st_next.rdata = {28'h0, st_reg.sync2};
            end
            SEL_STAT:
            begin
               st_next.rdata = {30'h0, st_reg.stat};
            end
            SEL_MASK:
            begin
               st_next.rdata = {30'h0, st_reg.mask};
            end
            default:
            begin
               st_next.err = 1'b1;
            end
         endcase
      end

      // sticky status events are set after the clear so a set wins
      if (st_next.req)
      begin
         st_next.stat[KIP_ST_KEY_BIT] = 1'b1;
      end
      if (st_next.rst_req && !st_reg.rst_req)
      begin
         st_next.stat[KIP_ST_HOLD_BIT] = 1'b1;
      end
      st_next.irq = |(st_next.stat & st_next.mask);
   end

   // state register
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         st_reg         <= '0;
         st_reg.mode    <= MODE_RST;
         st_reg.pull    <= PULL_RST;
         st_reg.rate    <= KIP_RATE_RST;
         st_reg.ie      <= KIP_IE_RST;
         st_reg.stat    <= KIP_STAT_RST;
         st_reg.mask    <= KIP_MASK_RST;
         st_reg.vec     <= VECTOR_ADDR;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flip-flops
   assign pready               = st_reg.ready;
   assign prdata               = st_reg.rdata;
   assign pslverr              = st_reg.err;
   assign pull_enable          = ~st_reg.mode;
   assign pull_up              = st_reg.pull;
   assign key_port_irq_request = st_reg.req;
   assign key_port_irq_flag    = st_reg.flag;
   assign irq_vector           = st_reg.vec;
   assign reset_mode_request   = st_reg.rst_req;
   assign irq                  = st_reg.irq;

endmodule // kip_port

// ### bench/kip_port_assertions.sv
`timescale 1ns/1ps
module kip_port_checker
   import kip_pkg::*;
#(
   parameter logic [3:0] MODE_RST = 4'h0,
   parameter logic       PULL_RST = 1'b0
)(
   // clock, reset and bus answer
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // pads and interrupt side
   input wire logic [3:0]  pull_enable,
   input wire logic        pull_up,
   input wire logic        key_port_irq_ack,
   input wire logic        key_port_irq_request,
   input wire logic        key_port_irq_flag,
   input wire logic [11:0] irq_vector
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // one wait state, then a single-cycle answer
   apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
   err_timing_a: assert property (pslverr |-> pready) else $error("error without ready");
   req_flag_a: assert property (key_port_irq_request |-> ##[0:1] key_port_irq_flag)
      else $error("request without flag");
   flag_hold_a: assert property (key_port_irq_flag && !key_port_irq_ack |=> key_port_irq_flag)
      else $error("flag dropped");
   req_pulse_a: assert property (key_port_irq_request |=> !key_port_irq_request)
      else $error("request not a pulse");
   vector_fix_a: assert property (irq_vector == 12'h01e) else $error("vector wrong");
   // reset is sampled itself here, so this one is never disabled
   reset_pads_a: assert property (disable iff (1'b0) !rstn |=> pull_enable == ~MODE_RST && pull_up == PULL_RST)
      else $error("pad reset wrong");
endmodule // kip_port_checker
bind kip_port kip_port_checker #(.MODE_RST(MODE_RST), .PULL_RST(PULL_RST)) chk (
   .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .pull_enable(pull_enable), .pull_up(pull_up),
   .key_port_irq_ack(key_port_irq_ack), .key_port_irq_request(key_port_irq_request),
   .key_port_irq_flag(key_port_irq_flag), .irq_vector(irq_vector));

// ### bench/kip_keys.sv
`timescale 1ns/1ps
module kip_keys (
   // key drive from the bench, pad controls from the port
   input wire logic       core_clk,
   input wire logic [3:0] drive_en,
   input wire logic [3:0] drive_val,
   input wire logic [3:0] pull_enable,
   input wire logic       pull_up,
   output logic [3:0]     key_pin
);
   logic [3:0] float_q = 4'h5;
   // an unterminated pin wanders, so no stale level can pass for a real one
   always_ff @(posedge core_clk) float_q <= ~float_q;
   always_comb
      for (int i = 0; i < 4; i++)
         key_pin[i] = drive_en[i] ? drive_val[i] : pull_enable[i] ? pull_up : float_q[i];
endmodule // kip_keys

// ### bench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
   $display("FAIL %s expected %h seen %h", n, e, a); end end
module testbench;
   import kip_pkg::*;
   localparam logic [11:0] a_mode = 12'(KIP_ADDR_MODE), a_ctrl = 12'(KIP_ADDR_CTRL);
   localparam logic [11:0] a_ie = 12'(KIP_ADDR_IE), a_lvl = 12'(KIP_ADDR_LEVEL);
   localparam logic [11:0] a_stat = 12'(KIP_ADDR_STAT), a_mask = 12'(KIP_ADDR_MASK);
   logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, ack = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q, lf = 32'h634e4317;
   logic [3:0] den = '0, dval = '0, pin, pen;
   logic pready, pslverr, pup, req, flag, rmr, irq, e;
   int err_count = 0, num_checks = 0;
   always #2.5 core_clk = ~core_clk;
   kip_keys keys (.core_clk(core_clk), .drive_en(den), .drive_val(dval), .pull_enable(pen),
      .pull_up(pup), .key_pin(pin));
   kip_port #(.SLOW_DIV(16), .FAST_DIV(4), .HOLD_TICKS(4)) uut (.core_clk(core_clk),
      .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .key_pin(pin),
      .pull_enable(pen), .pull_up(pup), .key_port_irq_ack(ack), .key_port_irq_request(req),
      .key_port_irq_flag(flag), .irq_vector(), .reset_mode_request(rmr), .irq(irq));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic results;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge core_clk) penable <= 1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      if (n == 20)
      begin
         err_count++;
         results();
      end
   endtask
   // bounded wait for the flag or the reset-mode request
   task automatic wt(input bit rm, input int lim);
      int n;
      for (n = 0; n < lim && (rm ? rmr : flag) !== 1'b1; n++) @(posedge core_clk);
      if (n == lim)
      begin
         err_count++;
         results();
      end
   endtask
   task automatic pk;
      @(posedge core_clk) ack <= 1;
      @(posedge core_clk) ack <= 0;
      @(posedge core_clk);
      `CHK("ack", 1'b0, flag)
   endtask
   initial
   begin
      repeat (20) @(posedge core_clk);
      rstn <= 1;
      `CHK("pen", 4'hf, pen)
      apb(0, a_ie, 0);
      `CHK("ie", 32'h0, q)
      apb(0, a_ctrl, 0);
      `CHK("ctrl", 32'h0, q)
      apb(0, 12'hffc, 0);
      `CHK("slverr", 1'b1, e)
      $display("test reset done");
      repeat (6)
      begin
         lf = nx(lf);
         apb(1, a_mode, {28'h0, lf[3:0]});
         apb(1, a_ctrl, {30'h0, lf[5:4]});
         apb(0, a_ctrl, 0);
         `CHK("ctrl", {30'h0, lf[5:4]}, q)
         `CHK("pen", ~lf[3:0], pen)
         `CHK("pup", lf[5], pup)
         den <= 4'hf;
         dval <= lf[11:8];
         apb(1, a_lvl, 32'hf);
         `CHK("lvl err", 1'b0, e)
         apb(0, a_lvl, 0);
         `CHK("level", {28'h0, lf[11:8]}, q)
      end
      $display("test registers done");
      den <= 4'h0;
      apb(1, a_mode, 0);
      apb(1, a_ctrl, 1);
      apb(1, a_ie, 1);
      apb(1, a_mask, 1);
      repeat (20) @(posedge core_clk);
      pk();
      apb(1, a_stat, 3);
      dval <= 4'h1;
      den <= 4'h1;
      wt(0, 10);
      `CHK("flag", 1'b1, flag)
      apb(0, a_lvl, 0);
      `CHK("cause", 32'h1, q)
      `CHK("irq", 1'b1, irq)
      apb(1, a_stat, 1);
      @(posedge core_clk);
      `CHK("irq", 1'b0, irq)
      pk();
      dval <= 4'h0;
      wt(0, 10);
      `CHK("flag", 1'b1, flag)
      pk();
      {den, dval} <= 8'h22;
      repeat (30) @(posedge core_clk);
      `CHK("flag", 1'b0, flag)
      den <= 4'h0;
      apb(1, a_ctrl, 2);
      repeat (40) @(posedge core_clk);
      pk();
      {den, dval} <= 8'h10;
      wt(0, 24);
      `CHK("flag", 1'b1, flag)
      $display("test interrupt done");
      den <= 4'h3;
      wt(1, 3000);
      `CHK("hold", 1'b1, rmr)
      $display("test hold done");
      results();
   end
endmodule // testbench
